// [src/aux_power_defines.svh]
// Named offsets, field positions, defaults and counts for the aux power block
`ifndef AUX_POWER_DEFINES_SVH
`define AUX_POWER_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// ----------------------------------------------------------------
`define AVM_ADDR_W 8
`define OFS_SWITCH_CONTROL_REG 8'h00
`define OFS_POWER_MGMT_CTRL_STATUS 8'h04
`define OFS_DEVICE_STATUS_REG 8'h08
`define OFS_FR_STICKY_REG 8'h0C
`define OFS_STICKY_REG 8'h10
`define OFS_LOCKABLE_REG 8'h14
`define OFS_ORDINARY_REG 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_AUX_EN 0
`define BIT_LOCK_UNLOCK 1
`define BIT_PME_EN 0
`define BIT_AUX_DET 0
`define BIT_L2_EN 1
`define FLD_STATE_LO 2
`define FLD_STATE_HI 3
`define BIT_FR_INIT 4
`define BIT_LATE_DONE 5
`define BYTE0_LANE 0

// ----------------------------------------------------------------
// Field widths and reset values
// ----------------------------------------------------------------
`define FIELD_W 8
`define FR_STICKY_DEFAULT 8'h00
`define STICKY_DEFAULT 8'h00
`define LOCKABLE_DEFAULT 8'h00
`define ORDINARY_DEFAULT 8'h00

// ----------------------------------------------------------------
// Sampling points after fundamental reset release, in core cycles
// ----------------------------------------------------------------
`define EARLY_SAMPLE_CYCLES 8
`define LATE_SAMPLE_CYCLES 256
`define SAMPLE_CNT_W 9

`endif

// [src/aux_power_pkg.sv]
// Types shared by the aux power and L2 mode control block
`include "aux_power_defines.svh"

package aux_power_pkg;

    // System power states seen by the device
    typedef enum logic [1:0]
    {
        st_off,
        st_inactive_standby,
        st_active_standby,
        st_on
    } sys_state_e;

    // One configuration field
    typedef logic [`FIELD_W-1:0] field_t;

endpackage

// [src/reset_sample_timer.sv]
// Cycle counter that marks the two sampling points after reset release
`timescale 1ns/1ps
`include "aux_power_defines.svh"

module reset_sample_timer
#(
    parameter int CNT_W = `SAMPLE_CNT_W,
    parameter int EARLY_CNT = `EARLY_SAMPLE_CYCLES,
    parameter int LATE_CNT = `LATE_SAMPLE_CYCLES
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic released,
    output logic early_pulse,
    output logic late_pulse
);

    localparam logic [CNT_W-1:0] EARLY_M1 = CNT_W'(EARLY_CNT - 1);
    localparam logic [CNT_W-1:0] LATE_M1 = CNT_W'(LATE_CNT - 1);
    localparam logic [CNT_W-1:0] LATE_END = CNT_W'(LATE_CNT);
    localparam int GAP = LATE_CNT - EARLY_CNT;

    logic [CNT_W-1:0] cnt_ff;
    logic early_ff;
    logic late_ff;

    // ------------------------------------------------------------
    // One counter serves both points, so they never drift apart
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || !released)
            cnt_ff <= '0;
        else if (cnt_ff != LATE_END)
            cnt_ff <= cnt_ff + CNT_W'(1);
    end

    // Registered pulses; high in the cycle the count equals the point
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            early_ff <= 1'b0;
            late_ff <= 1'b0;
        end
        else
        begin
            early_ff <= released && (cnt_ff == EARLY_M1);
            late_ff <= released && (cnt_ff == LATE_M1);
        end
    end

    assign early_pulse = early_ff;
    assign late_pulse = late_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // A dropped release restarts the count, so it also ends the attempt
    property p_shared_origin;
        @(posedge core_clk) disable iff (sys_rst || !released)
        early_ff |-> ##GAP late_ff;
    endproperty
    a_shared_origin: assert property (p_shared_origin)
        else $error("late sample not at its fixed gap after early sample");

endmodule

// [src/aux_power_l2_mode_control.sv]
// Aux power usage, L2 enable, standby state and reset-class field storage
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "aux_power_defines.svh"

module aux_power_l2_mode_control
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic fundamental_reset_n,
    input wire logic aux_power_disable_n,
    input wire logic main_power_good,
    input wire logic aux_power_good,
    input wire logic hot_reset,
    input wire logic [`AVM_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic aux_power_detected,
    output logic l2_mode_enabled,
    output aux_power_pkg::sys_state_e sys_state,
    output logic wake_beacon_power_en,
    output logic core_clk_gate
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Bit order: reset, disable, main good, aux good
    logic [3:0] pin_meta_ff;
    logic [3:0] pin_sync_ff;
    logic freset_n_s;
    logic disable_n_s;
    logic main_s;
    logic aux_s;

    // Two stages; only the second stage is read by logic
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pin_meta_ff <= 4'h0;
            pin_sync_ff <= 4'h0;
        end
        else
        begin
            pin_meta_ff <= {aux_power_good, main_power_good,
                            aux_power_disable_n, fundamental_reset_n};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign freset_n_s = pin_sync_ff[0];
    assign disable_n_s = pin_sync_ff[1];
    assign main_s = pin_sync_ff[2];
    assign aux_s = pin_sync_ff[3];

    // ------------------------------------------------------------
    // Sampling points
    // ------------------------------------------------------------
    logic early_pulse;
    logic late_pulse;

    reset_sample_timer u_timer
    (
        .core_clk (core_clk),
        .sys_rst (sys_rst),
        .released (freset_n_s),
        .early_pulse (early_pulse),
        .late_pulse (late_pulse)
    );

    // ------------------------------------------------------------
    // Avalon-MM slave handshake
    // ------------------------------------------------------------
    logic waitrequest_ff;
    logic [31:0] readdata_ff;
    logic wr_fire;
    logic [31:0] rd_mux;

    // Every access is answered one cycle after it appears
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            waitrequest_ff <= 1'b1;
        else if ((read || write) && waitrequest_ff)
            waitrequest_ff <= 1'b0;
        else
            waitrequest_ff <= 1'b1;
    end

    // Writes land only at the edge where waitrequest is seen low
    assign wr_fire = write && !waitrequest_ff && byteenable[`BYTE0_LANE];

    // ------------------------------------------------------------
    // Control and status state
    // ------------------------------------------------------------
    logic aux_en_ff;
    logic lock_unlock_ff;
    logic pme_en_ff;
    logic aux_det_ff;
    logic l2_en_ff;
    logic fr_init_ff;
    logic late_done_ff;
    logic usage_ok;
    logic ord_rst;
    logic sticky_rst;
    logic fr_init_now;
    aux_power_pkg::sys_state_e state_ff;
    aux_power_pkg::sys_state_e nxt_state;
    aux_power_pkg::field_t fr_sticky_ff;
    aux_power_pkg::field_t sticky_ff;
    aux_power_pkg::field_t lockable_ff;
    aux_power_pkg::field_t ordinary_ff;
    logic wake_pwr_ff;
    logic clk_gate_ff;

    // Reset classes: ordinary fields see every reset, sticky ones not hot
    assign ord_rst = sys_rst || !freset_n_s || hot_reset;
    assign sticky_rst = sys_rst || !freset_n_s;
    // Sticky contents die at an early low sample or with no aux save
    assign fr_init_now = (early_pulse && !disable_n_s)
                       || (state_ff == aux_power_pkg::st_inactive_standby)
                       || (state_ff == aux_power_pkg::st_off);
    // Aux supply may only be used with PME from D3cold enabled
    assign usage_ok = aux_det_ff && pme_en_ff;

    // Aux enable: late sample wins over a software write that cycle
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            aux_en_ff <= 1'b0;
        else if (late_pulse)
            aux_en_ff <= disable_n_s;
        else if (wr_fire && address == `OFS_SWITCH_CONTROL_REG)
            aux_en_ff <= writedata[`BIT_AUX_EN] && pme_en_ff;
    end

    // Unlock for the lockable field is an ordinary field
    always_ff @(posedge core_clk)
    begin
        if (ord_rst)
            lock_unlock_ff <= 1'b0;
        else if (wr_fire && address == `OFS_SWITCH_CONTROL_REG)
            lock_unlock_ff <= writedata[`BIT_LOCK_UNLOCK];
    end

    // PME enable is part of the fundamental-reset-sticky context
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || fr_init_now)
            pme_en_ff <= 1'b0;
        else if (wr_fire && address == `OFS_POWER_MGMT_CTRL_STATUS)
            pme_en_ff <= writedata[`BIT_PME_EN];
    end

    // Detected is a mirror of the enable, never of a supply pin
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            aux_det_ff <= 1'b0;
            l2_en_ff <= 1'b0;
        end
        else
        begin
            aux_det_ff <= aux_en_ff;
            l2_en_ff <= aux_det_ff && pme_en_ff;
        end
    end

    // Status of the last sampling sequence, for software to inspect
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            fr_init_ff <= 1'b0;
            late_done_ff <= 1'b0;
        end
        else
        begin
            if (early_pulse)
                fr_init_ff <= !disable_n_s;
            if (!freset_n_s)
                late_done_ff <= 1'b0;
            else if (late_pulse)
                late_done_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Configuration fields, one per reset class plus a lockable one on the sticky reset
    // ------------------------------------------------------------
    // Survives hot, warm and cold resets; early low sample clears it
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || fr_init_now)
            fr_sticky_ff <= `FR_STICKY_DEFAULT;
        else if (wr_fire && address == `OFS_FR_STICKY_REG)
            fr_sticky_ff <= writedata[`FIELD_W-1:0];
    end

    // Sticky field keeps its value across hot reset
    always_ff @(posedge core_clk)
    begin
        if (sticky_rst)
            sticky_ff <= `STICKY_DEFAULT;
        else if (wr_fire && address == `OFS_STICKY_REG)
            sticky_ff <= writedata[`FIELD_W-1:0];
    end

    // Lockable field: writes ignored unless unlocked
    always_ff @(posedge core_clk)
    begin
        if (sticky_rst)
            lockable_ff <= `LOCKABLE_DEFAULT;
        else if (wr_fire && address == `OFS_LOCKABLE_REG && lock_unlock_ff)
            lockable_ff <= writedata[`FIELD_W-1:0];
    end

    // Ordinary field returns to default on any reset
    always_ff @(posedge core_clk)
    begin
        if (ord_rst)
            ordinary_ff <= `ORDINARY_DEFAULT;
        else if (wr_fire && address == `OFS_ORDINARY_REG)
            ordinary_ff <= writedata[`FIELD_W-1:0];
    end

    // ------------------------------------------------------------
    // System power state
    // ------------------------------------------------------------
    // Main power alone decides on; aux decides off, usage_ok picks standby flavour
    always_comb
    begin
        if (main_s)
            nxt_state = aux_power_pkg::st_on;
        else if (!aux_s)
            nxt_state = aux_power_pkg::st_off;
        else if (usage_ok)
            nxt_state = aux_power_pkg::st_active_standby;
        else
            nxt_state = aux_power_pkg::st_inactive_standby;
    end

    // Wake/beacon supply and clock gate follow the state directly
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_ff <= aux_power_pkg::st_off;
            wake_pwr_ff <= 1'b0;
            clk_gate_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            wake_pwr_ff <= (nxt_state == aux_power_pkg::st_active_standby);
            clk_gate_ff <= (nxt_state == aux_power_pkg::st_active_standby);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Unmapped offsets read as zero rather than erroring
    always_comb
    begin
        rd_mux = '0;
        unique case (address)
            `OFS_SWITCH_CONTROL_REG:
            begin
                rd_mux[`BIT_AUX_EN] = aux_en_ff;
                rd_mux[`BIT_LOCK_UNLOCK] = lock_unlock_ff;
            end
            `OFS_POWER_MGMT_CTRL_STATUS:
                rd_mux[`BIT_PME_EN] = pme_en_ff;
            `OFS_DEVICE_STATUS_REG:
            begin
                rd_mux[`BIT_AUX_DET] = aux_det_ff;
                rd_mux[`BIT_L2_EN] = l2_en_ff;
                rd_mux[`FLD_STATE_HI:`FLD_STATE_LO] = state_ff;
                rd_mux[`BIT_FR_INIT] = fr_init_ff;
                rd_mux[`BIT_LATE_DONE] = late_done_ff;
            end
            `OFS_FR_STICKY_REG:
                rd_mux[`FIELD_W-1:0] = fr_sticky_ff;
            `OFS_STICKY_REG:
                rd_mux[`FIELD_W-1:0] = sticky_ff;
            `OFS_LOCKABLE_REG:
                rd_mux[`FIELD_W-1:0] = lockable_ff;
            `OFS_ORDINARY_REG:
                rd_mux[`FIELD_W-1:0] = ordinary_ff;
            default:
                rd_mux = '0;
        endcase
    end

    // Captured when the answer is issued, held until the next one
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            readdata_ff <= '0;
        else if (read && waitrequest_ff)
            readdata_ff <= rd_mux;
    end

    assign readdata = readdata_ff;
    assign waitrequest = waitrequest_ff;
    assign aux_power_detected = aux_det_ff;
    assign l2_mode_enabled = l2_en_ff;
    assign sys_state = state_ff;
    assign wake_beacon_power_en = wake_pwr_ff;
    assign core_clk_gate = clk_gate_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_early_low_init;
        early_pulse && !disable_n_s |=> fr_sticky_ff == `FR_STICKY_DEFAULT
            && !pme_en_ff;
    endproperty
    a_early_low_init: assert property (p_early_low_init)
        else $error("sticky field not initialised on early low sample");

    property p_early_high_keep;
        early_pulse && disable_n_s && !wr_fire && main_s
            |=> $stable(fr_sticky_ff);
    endproperty
    a_early_high_keep: assert property (p_early_high_keep)
        else $error("sticky field changed on early high sample");

    property p_late_sample;
        late_pulse |=> aux_en_ff == $past(disable_n_s) ##1 aux_det_ff
            == $past(disable_n_s, 2);
    endproperty
    a_late_sample: assert property (p_late_sample)
        else $error("aux enable or detected wrong after late sample");

    property p_sw_enable;
        $rose(aux_en_ff) |-> $past(late_pulse) || $past(pme_en_ff);
    endproperty
    a_sw_enable: assert property (p_sw_enable)
        else $error("aux enable set without PME enable");

    property p_l2_enable;
        l2_en_ff |-> $past(aux_en_ff, 2) && $past(pme_en_ff);
    endproperty
    a_l2_enable: assert property (p_l2_enable)
        else $error("L2 enabled without aux detected and PME enable");

    property p_active_standby;
        state_ff == aux_power_pkg::st_active_standby |-> wake_pwr_ff
            && clk_gate_ff && !$past(main_s) && $past(usage_ok);
    endproperty
    a_active_standby: assert property (p_active_standby)
        else $error("active standby without wake power or gate");

    property p_inactive_lose;
        state_ff == aux_power_pkg::st_inactive_standby |=> !wake_pwr_ff
            && fr_sticky_ff == `FR_STICKY_DEFAULT;
    endproperty
    a_inactive_lose: assert property (p_inactive_lose)
        else $error("inactive standby kept sticky or wake power");

    property p_hot_reset_classes;
        hot_reset && freset_n_s && !wr_fire |=> ordinary_ff
            == `ORDINARY_DEFAULT && $stable(sticky_ff)
            && $stable(lockable_ff);
    endproperty
    a_hot_reset_classes: assert property (p_hot_reset_classes)
        else $error("hot reset handled field classes wrongly");

    c_early_low: cover property (early_pulse && !disable_n_s);
    c_early_high: cover property (early_pulse && disable_n_s);
    c_active: cover property
        (state_ff == aux_power_pkg::st_active_standby);

endmodule

// [verification/por_partner_model.sv]
// Model of the external power-on-reset circuitry and supply rails
`timescale 1ns/1ps

module por_partner_model
(
    input wire logic core_clk,
    output logic fundamental_reset_n,
    output logic aux_power_disable_n,
    output logic main_power_good,
    output logic aux_power_good
);
    // ----------------------------------------------------------------
    // Pin levels at time zero
    // ----------------------------------------------------------------
    // Rails off and reset held until the bench powers up
    initial
    begin
        fundamental_reset_n = 1'b0;
        aux_power_disable_n = 1'b0;
        main_power_good = 1'b0;
        aux_power_good = 1'b0;
    end

    // ----------------------------------------------------------------
    // Sequences
    // ----------------------------------------------------------------
    // Rail change; waits well past the pin synchronisers
    task automatic set_power(input logic main_on, input logic aux_on);
        main_power_good <= main_on;
        aux_power_good <= aux_on;
        repeat (10) @(posedge core_clk);
    endtask

    // Disable pin made to match the software enable
    task automatic set_disable(input logic lvl);
        aux_power_disable_n <= lvl;
        repeat (4) @(posedge core_clk);
    endtask

    // Reset pulse; pin held stable across each sample with margin
    task automatic reset_cycle(input logic early_lvl, input logic late_lvl);
        fundamental_reset_n <= 1'b0;
        aux_power_disable_n <= early_lvl;
        repeat (10) @(posedge core_clk);
        fundamental_reset_n <= 1'b1;
        repeat (100) @(posedge core_clk);
        aux_power_disable_n <= late_lvl;
        repeat (260) @(posedge core_clk);
    endtask
endmodule

// [verification/aux_power_l2_mode_control_tb.sv]
// Self-checking bench for the aux power and L2 mode control block
`timescale 1ns/1ps
`include "aux_power_defines.svh"

module aux_power_l2_mode_control_tb;
    logic core_clk;
    logic sys_rst;
    logic fundamental_reset_n;
    logic aux_power_disable_n;
    logic main_power_good;
    logic aux_power_good;
    logic hot_reset;
    logic [`AVM_ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    logic aux_power_detected;
    logic l2_mode_enabled;
    aux_power_pkg::sys_state_e sys_state;
    logic wake_beacon_power_en;
    logic core_clk_gate;
    int fail_count;
    int compares;

    aux_power_l2_mode_control dut
    (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .fundamental_reset_n(fundamental_reset_n),
        .aux_power_disable_n(aux_power_disable_n),
        .main_power_good(main_power_good),
        .aux_power_good(aux_power_good),
        .hot_reset(hot_reset),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .byteenable(byteenable),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .aux_power_detected(aux_power_detected),
        .l2_mode_enabled(l2_mode_enabled),
        .sys_state(sys_state),
        .wake_beacon_power_en(wake_beacon_power_en),
        .core_clk_gate(core_clk_gate)
    );

    por_partner_model por
    (
        .core_clk(core_clk),
        .fundamental_reset_n(fundamental_reset_n),
        .aux_power_disable_n(aux_power_disable_n),
        .main_power_good(main_power_good),
        .aux_power_good(aux_power_good)
    );

    // ----------------------------------------------------------------
    // Clock and shared tasks
    // ----------------------------------------------------------------
    // 200 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One bus cycle; the extra edge keeps back-to-back drives apart
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        @(posedge core_clk);
        while (waitrequest !== 1'b0 && n < 50)
        begin
            @(posedge core_clk);
            n++;
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50)
            fail_count++;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(q, exp);
    endtask

    // Expected status word from its fields
    function automatic logic [31:0] st(input logic ld, input logic el,
        input logic [1:0] s, input logic l2, input logic det);
        return {26'h000_0000, ld, el, s, l2, det};
    endfunction

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic disable_tied_low;
        por.set_power(1'b1, 1'b1);
        wr(`OFS_FR_STICKY_REG, 32'h0000_005A);
        por.reset_cycle(1'b0, 1'b0);
        rd(`OFS_FR_STICKY_REG, 32'h0000_0000);
        rd(`OFS_DEVICE_STATUS_REG, st(1, 1, 2'd3, 0, 0));
        chk(32'(aux_power_detected), 32'h0000_0000);
    endtask

    task automatic disable_held_high;
        wr(`OFS_POWER_MGMT_CTRL_STATUS, 32'h0000_0001);
        wr(`OFS_FR_STICKY_REG, 32'h0000_00A5);
        wr(`OFS_ORDINARY_REG, 32'h0000_0077);
        por.reset_cycle(1'b1, 1'b1);
        rd(`OFS_FR_STICKY_REG, 32'h0000_00A5);
        rd(`OFS_POWER_MGMT_CTRL_STATUS, 32'h0000_0001);
        rd(`OFS_ORDINARY_REG, 32'h0000_0000);
        rd(`OFS_DEVICE_STATUS_REG, st(1, 0, 2'd3, 1, 1));
        chk(32'(aux_power_detected), 32'h0000_0001);
        chk(32'(l2_mode_enabled), 32'h0000_0001);
    endtask

    task automatic early_high_late_low;
        por.reset_cycle(1'b1, 1'b0);
        rd(`OFS_DEVICE_STATUS_REG, st(1, 0, 2'd3, 0, 0));
        rd(`OFS_FR_STICKY_REG, 32'h0000_00A5);
    endtask

    task automatic software_enable;
        wr(`OFS_POWER_MGMT_CTRL_STATUS, 32'h0000_0000);
        wr(`OFS_SWITCH_CONTROL_REG, 32'h0000_0001);
        rd(`OFS_SWITCH_CONTROL_REG, 32'h0000_0000);
        wr(`OFS_POWER_MGMT_CTRL_STATUS, 32'h0000_0001);
        wr(`OFS_SWITCH_CONTROL_REG, 32'h0000_0003);
        por.set_disable(1'b1);
        rd(`OFS_SWITCH_CONTROL_REG, 32'h0000_0003);
        chk(32'(aux_power_detected), 32'h0000_0001);
        chk(32'(l2_mode_enabled), 32'h0000_0001);
    endtask

    task automatic hot_reset_classes;
        wr(`OFS_LOCKABLE_REG, 32'h0000_003C);
        wr(`OFS_STICKY_REG, 32'h0000_0011);
        wr(`OFS_ORDINARY_REG, 32'h0000_0022);
        hot_reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        hot_reset <= 1'b0;
        @(posedge core_clk);
        rd(`OFS_ORDINARY_REG, 32'h0000_0000);
        rd(`OFS_STICKY_REG, 32'h0000_0011);
        rd(`OFS_LOCKABLE_REG, 32'h0000_003C);
        rd(`OFS_FR_STICKY_REG, 32'h0000_00A5);
        wr(`OFS_LOCKABLE_REG, 32'h0000_0099);
        rd(`OFS_LOCKABLE_REG, 32'h0000_003C);
        rd(8'h1C, 32'h0000_0000);
        byteenable <= 4'h0;
        wr(`OFS_ORDINARY_REG, 32'h0000_0055);
        byteenable <= 4'h1;
        rd(`OFS_ORDINARY_REG, 32'h0000_0000);
    endtask

    task automatic standby_states;
        por.set_power(1'b0, 1'b1);
        chk(32'(sys_state), 32'(aux_power_pkg::st_active_standby));
        chk(32'(wake_beacon_power_en), 32'h0000_0001);
        chk(32'(core_clk_gate), 32'h0000_0001);
        por.set_power(1'b1, 1'b1);
        chk(32'(sys_state), 32'(aux_power_pkg::st_on));
        rd(`OFS_FR_STICKY_REG, 32'h0000_00A5);
        wr(`OFS_SWITCH_CONTROL_REG, 32'h0000_0000);
        por.set_disable(1'b0);
        por.set_power(1'b0, 1'b1);
        chk(32'(sys_state), 32'(aux_power_pkg::st_inactive_standby));
        chk(32'(wake_beacon_power_en), 32'h0000_0000);
        chk(32'(core_clk_gate), 32'h0000_0000);
        por.set_power(1'b1, 1'b1);
        rd(`OFS_FR_STICKY_REG, 32'h0000_0000);
        por.set_power(1'b0, 1'b0);
        chk(32'(sys_state), 32'(aux_power_pkg::st_off));
    endtask

    // ----------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        $display("Compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Whole run is near 1300 cycles; this allows ample margin
    initial
    begin
        #100us;
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        fail_count = 0;
        compares = 0;
        sys_rst = 1'b1;
        hot_reset = 1'b0;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'h1;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        disable_tied_low();
        disable_held_high();
        early_high_late_low();
        software_enable();
        hot_reset_classes();
        standby_states();
        report_and_stop();
    end
endmodule
